// ==== flash_array.sv ====
`include "flash_prot_params.svh"

module flash_array #(
  parameter int WORDS = `FLASH_BYTES / 4,
  parameter int DATA_W = `FLASH_DATA_W,
  parameter int WADDR_W = $clog2(WORDS)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wen,
  input wire logic [WADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ren,
  input wire logic clr,
  input wire logic [WADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  // non-volatile contents: no reset on the cells
  logic [DATA_W-1:0] mem [WORDS];

  always_ff @(posedge core_clk) begin
    if (wen) begin
      mem[waddr] <= wdata;
    end
  end

  // refused or non-read answers show zero, never stale contents
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `READ_CLEAR_WORD;
    end else if (ren) begin
      rdata <= mem[raddr];
    end else if (clr) begin
      rdata <= `READ_CLEAR_WORD;
    end
  end

endmodule

// ==== flash_prot.sv ====
`include "flash_prot_params.svh"

module flash_prot import flash_prot_pkg::*; #(
  parameter int FLASH_BYTES = `FLASH_BYTES,
  parameter int ERASE_BLK_BYTES = `ERASE_BLK_BYTES,
  parameter int PROT_UNIT_BYTES = `PROT_UNIT_BYTES,
  parameter int ADDR_W = `FLASH_ADDR_W,
  parameter int DATA_W = `FLASH_DATA_W,
  parameter int UNITS = FLASH_BYTES / PROT_UNIT_BYTES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire flash_req_t req,
  output logic req_ready,
  input wire logic [UNITS-1:0] prot_read_only,
  input wire logic [UNITS-1:0] prot_exec_only,
  output flash_resp_t resp,
  output logic [DATA_W-1:0] rdata
);

  localparam int WORDS = FLASH_BYTES / 4;
  localparam int WADDR_W = $clog2(WORDS);
  localparam int BLK_SHIFT = $clog2(ERASE_BLK_BYTES);
  localparam int BLK_W = ADDR_W - BLK_SHIFT;
  localparam int CNT_W = BLK_SHIFT - `BYTE_LANE_SHIFT;
  localparam int UNIT_SHIFT = $clog2(PROT_UNIT_BYTES);
  localparam int UNIT_W = ADDR_W - UNIT_SHIFT;
  localparam logic [CNT_W-1:0] CNT_LAST = '1;

  function automatic logic [UNIT_W-1:0] unit_of(input logic [ADDR_W-1:0] a);
    unit_of = a[ADDR_W-1:UNIT_SHIFT];
  endfunction

  function automatic logic [BLK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
    block_of = a[ADDR_W-1:BLK_SHIFT];
  endfunction

  erase_state_t state;
  erase_state_t next_state;
  logic [CNT_W-1:0] erase_cnt;
  logic [BLK_W-1:0] erase_blk;
  logic resp_valid;
  logic resp_refused;

  // per-unit permissions
  logic [UNITS-1:0] unit_write_ok;
  logic [UNITS-1:0] unit_data_ok;

  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_unit
      // two marks per unit
      // execute-only wins when both marks are set: stricter of the two
      assign unit_write_ok[u] = !prot_read_only[u] && !prot_exec_only[u];
      assign unit_data_ok[u] = !prot_exec_only[u];
    end
  endgenerate

  wire logic [UNIT_W-1:0] req_unit = unit_of(req.addr);
  wire logic is_fetch = (req.kind == KIND_FETCH);
  wire logic is_data_rd = (req.kind == KIND_DATA_RD) || (req.kind == KIND_DEBUG_RD);
  wire logic is_program = (req.kind == KIND_PROGRAM);
  wire logic is_erase = (req.kind == KIND_ERASE);
  wire logic is_read = is_fetch || is_data_rd;

  wire logic allow = is_fetch ? 1'b1 :
                     is_data_rd ? unit_data_ok[req_unit] :
                     (is_program || is_erase) ? unit_write_ok[req_unit] : 1'b0;

  wire logic take = req_valid && req_ready;
  wire logic erasing = (state == ST_ERASE);
  wire logic erase_done = erasing && (erase_cnt == CNT_LAST);
  wire logic start_erase = take && is_erase && allow;

  // erase walks only the latched block
  wire logic mem_wen = erasing || (take && is_program && allow);
  wire logic [WADDR_W-1:0] mem_waddr = erasing ? {erase_blk, erase_cnt} :
                                       req.addr[ADDR_W-1:`BYTE_LANE_SHIFT];
  wire logic [DATA_W-1:0] mem_wdata = erasing ? `ERASED_WORD : req.wdata;
  wire logic mem_ren = take && is_read && allow;
  wire logic mem_clr = take && !mem_ren;

  assign req_ready = !erasing;
  assign resp.valid = resp_valid;
  assign resp.refused = resp_refused;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_erase) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (erase_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_cnt <= '0;
      erase_blk <= '0;
    end else if (start_erase) begin
      erase_cnt <= '0;
      erase_blk <= block_of(req.addr);
    end else if (erasing) begin
      erase_cnt <= erase_cnt + 1'b1;
    end
  end

  // one answer per request; an accepted erase answers when the block is done
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_refused <= 1'b0;
    end else begin
      resp_valid <= erase_done || (take && !start_erase);
      resp_refused <= take && !allow;
    end
  end

  flash_array #(
    .WORDS(WORDS),
    .DATA_W(DATA_W),
    .WADDR_W(WADDR_W)
  ) u_array (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wen(mem_wen),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .ren(mem_ren),
    .clr(mem_clr),
    .raddr(req.addr[ADDR_W-1:`BYTE_LANE_SHIFT]),
    .rdata(rdata)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_erase_start;
    req_valid && req_ready && req.kind == KIND_ERASE && allow;
  endsequence

  sequence s_erase_walk;
    (erasing && !resp_valid && mem_wen) [*8];
  endsequence

  property p_erase_in_block;
    erasing |-> mem_waddr[WADDR_W-1:CNT_W] == erase_blk && mem_wdata == `ERASED_WORD;
  endproperty
  a_erase_in_block: assert property (p_erase_in_block) else $error("erase left its block");

  property p_erase_walk;
    s_erase_start |=> s_erase_walk;
  endproperty
  a_erase_walk: assert property (p_erase_walk) else $error("erase walk not steady");

  property p_erase_finish;
    s_erase_start |-> ##257 (resp_valid && !resp_refused && !erasing);
  endproperty
  a_erase_finish: assert property (p_erase_finish) else $error("erase length wrong");

  property p_unit_select;
    (req_valid && req_ready && is_program) |->
      (mem_wen == !(prot_read_only[unit_of(req.addr)] || prot_exec_only[unit_of(req.addr)]));
  endproperty
  a_unit_select: assert property (p_unit_select) else $error("wrong unit checked");

  property p_ro_refuse;
    (req_valid && req_ready && (is_program || is_erase) && prot_read_only[req_unit])
      |-> !mem_wen ##1 (resp_valid && resp_refused && !erasing);
  endproperty
  a_ro_refuse: assert property (p_ro_refuse) else $error("read-only unit altered");

  property p_ro_read;
    (req_valid && req_ready && is_data_rd && prot_read_only[req_unit]
      && !prot_exec_only[req_unit]) |=> (resp_valid && !resp_refused);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("read-only unit read refused");

  property p_xo_data;
    (req_valid && req_ready && is_data_rd && prot_exec_only[req_unit])
      |=> (resp_valid && resp_refused && rdata == `READ_CLEAR_WORD);
  endproperty
  a_xo_data: assert property (p_xo_data) else $error("execute-only data leaked");

  property p_xo_fetch;
    (req_valid && req_ready && is_fetch) |=> (resp_valid && !resp_refused);
  endproperty
  a_xo_fetch: assert property (p_xo_fetch) else $error("fetch refused");

  property p_open_accept;
    (req_valid && req_ready && !prot_read_only[req_unit] && !prot_exec_only[req_unit])
      |-> allow ##1 !resp_refused;
  endproperty
  a_open_accept: assert property (p_open_accept) else $error("open unit refused");

endmodule

// ==== flash_prot_params.svh ====
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH

`define FLASH_BYTES 65536
`define FLASH_ADDR_W 16
`define FLASH_DATA_W 32
`define ERASE_BLK_BYTES 1024
`define PROT_UNIT_BYTES 2048
`define BYTE_LANE_SHIFT 2
`define ERASED_WORD 32'hFFFF_FFFF
`define READ_CLEAR_WORD 32'h0000_0000
`define RESP_LATENCY 1

`endif

// ==== flash_prot_pkg.sv ====
`include "flash_prot_params.svh"

package flash_prot_pkg;

  typedef enum logic [2:0] {
    KIND_FETCH,
    KIND_DATA_RD,
    KIND_DEBUG_RD,
    KIND_PROGRAM,
    KIND_ERASE
  } req_kind_t;

  typedef struct packed {
    req_kind_t kind;
    logic [`FLASH_ADDR_W-1:0] addr;
    logic [`FLASH_DATA_W-1:0] wdata;
  } flash_req_t;

  typedef struct packed {
    logic valid;
    logic refused;
  } flash_resp_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ERASE
  } erase_state_t;

endpackage

// ==== flash_requester.sv ====
module flash_requester import flash_prot_pkg::*; (
  input wire logic core_clk,
  input wire logic req_ready,
  output logic req_valid,
  output flash_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // ready only moves on the rising edge, so the falling edge sees the value the take uses
  task automatic issue(input req_kind_t k, input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk);
    req_valid = 1'b1;
    req = '{kind: k, addr: a, wdata: d};
    while (req_ready !== 1'b1) begin
      @(negedge core_clk);
    end
    @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 1'b0;
    // released bus shows inverted junk, not the old request
    req = ~req;
  endtask
endmodule

// ==== tb_flash_prot.sv ====
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected %s expected %h seen %h", name, exp, got); end end

module tb_flash_prot import flash_prot_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic on;
    req_kind_t kind;
    logic [15:0] addr;
    logic [31:0] wd;
    logic rf;
    logic [31:0] rd;
    int lat;
  } row_t;

  logic core_clk;
  logic rst_n;
  logic req_valid;
  flash_req_t req;
  logic req_ready;
  logic [31:0] prot_read_only;
  logic [31:0] prot_exec_only;
  flash_resp_t resp;
  logic [31:0] rdata;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;

  // unit 2 read-only, unit 3 execute-only, unit 4 carries both marks
  row_t rows[19] = '{
    '{0, KIND_ERASE, 16'h0400, 32'h0, 0, 32'h0, 257},
    '{0, KIND_DATA_RD, 16'h07FC, 32'h0, 0, 32'hFFFF_FFFF, 1},
    '{0, KIND_PROGRAM, 16'h0400, 32'hAAAA_5555, 0, 32'h0, 1},
    '{0, KIND_FETCH, 16'h0400, 32'h0, 0, 32'hAAAA_5555, 1},
    '{0, KIND_PROGRAM, 16'h1000, 32'h1111_1111, 0, 32'h0, 1},
    '{0, KIND_PROGRAM, 16'h1800, 32'h2222_2222, 0, 32'h0, 1},
    '{0, KIND_PROGRAM, 16'h2000, 32'h3333_3333, 0, 32'h0, 1},
    '{0, KIND_PROGRAM, 16'h0800, 32'h4444_4444, 0, 32'h0, 1},
    '{0, KIND_ERASE, 16'h0000, 32'h0, 0, 32'h0, 257},
    '{0, KIND_DEBUG_RD, 16'h0400, 32'h0, 0, 32'hAAAA_5555, 1},
    '{1, KIND_ERASE, 16'h1000, 32'h0, 1, 32'h0, 1},
    '{1, KIND_PROGRAM, 16'h1000, 32'h0, 1, 32'h0, 1},
    '{1, KIND_DEBUG_RD, 16'h1000, 32'h0, 0, 32'h1111_1111, 1},
    '{1, KIND_ERASE, 16'h1C00, 32'h0, 1, 32'h0, 1},
    '{1, KIND_DATA_RD, 16'h1800, 32'h0, 1, 32'h0, 1},
    '{1, KIND_DEBUG_RD, 16'h1800, 32'h0, 1, 32'h0, 1},
    '{1, KIND_FETCH, 16'h1800, 32'h0, 0, 32'h2222_2222, 1},
    '{1, KIND_DATA_RD, 16'h2000, 32'h0, 1, 32'h0, 1},
    '{1, KIND_DATA_RD, 16'h0800, 32'h0, 0, 32'h4444_4444, 1}
  };

  flash_prot i_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .prot_read_only(prot_read_only),
    .prot_exec_only(prot_exec_only),
    .resp(resp),
    .rdata(rdata)
  );

  flash_requester i_req (
    .core_clk(core_clk),
    .req_ready(req_ready),
    .req_valid(req_valid),
    .req(req)
  );

  initial begin
    core_clk = 1'b0;
    forever begin
      #25 core_clk = ~core_clk;
    end
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs about 570 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    prot_read_only = '0;
    prot_exec_only = '0;
    // the clock's first value at time zero may look like a falling edge
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK("ready in reset", 1'b1, req_ready)
    `CHK("resp in reset", 2'b00, resp)
    `CHK("rdata in reset", 32'h0, rdata)
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      prot_read_only = rows[i].on ? 32'h0000_0014 : 32'h0;
      prot_exec_only = rows[i].on ? 32'h0000_0018 : 32'h0;
      i_req.issue(rows[i].kind, rows[i].addr, rows[i].wd);
      n = 1;
      while (resp.valid !== 1'b1 && n < 300) begin
        `CHK("ready in erase walk", 1'b0, req_ready)
        @(negedge core_clk);
        n++;
      end
      `CHK("answer latency", rows[i].lat, n)
      `CHK("refused", rows[i].rf, resp.refused)
      `CHK("read data", rows[i].rd, rdata)
    end
    // reset in mid-walk must drop the erase at once
    prot_read_only = '0;
    prot_exec_only = '0;
    i_req.issue(KIND_ERASE, 16'h0C00, 32'h0);
    repeat (10) @(negedge core_clk);
    `CHK("ready in erase walk", 1'b0, req_ready)
    rst_n = 1'b0;
    @(negedge core_clk);
    `CHK("ready after reset", 1'b1, req_ready)
    `CHK("resp after reset", 2'b00, resp)
    `CHK("rdata after reset", 32'h0, rdata)
    rst_n = 1'b1;
    // the cut walk on block 3 must have left block 1 alone
    i_req.issue(KIND_DATA_RD, 16'h0400, 32'h0);
    `CHK("answer after reset", 1'b1, resp.valid)
    `CHK("read data after reset", 32'hAAAA_5555, rdata)
    summarize();
  end
endmodule
